/* File: hw/psr_mul_map.svh */
`ifndef PSR_MUL_MAP_SVH
`define PSR_MUL_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define REG_INSTR        6'h00
`define REG_OP_FIRST     6'h04
`define REG_OP_MULT      6'h08
`define REG_OP_ACC       6'h0C
`define REG_CUR_STATUS   6'h10
`define REG_SAVED_STATUS 6'h14
`define REG_RESULT       6'h18
`define REG_EXEC_STATE   6'h1C

// ****************************************************************
// Status word layout
// ****************************************************************
`define PSR_DEFINED_MASK 32'hF00000FF
`define PSR_FLAGS_MASK   32'hF0000000
`define PSR_N            31
`define PSR_Z            30
`define PSR_C            29
`define PSR_V            28
`define PSR_RESET        32'h000000D3

// ****************************************************************
// Processor modes
// ****************************************************************
`define MODE_USR 5'h10
`define MODE_FAST 5'h11
`define MODE_IRQ 5'h12
`define MODE_SVC 5'h13
`define MODE_ABT 5'h17
`define MODE_UND 5'h1B
`define SAVED_BANKS 5
`define BANK_NONE 3'h7

// ****************************************************************
// Instruction encodings
// ****************************************************************
`define ENC_PSR_CLASS  5'h02
`define ENC_READ_MID   6'h0F
`define ENC_WRITE_ALL  10'h29F
`define ENC_WRITE_FLG  10'h28F
`define ENC_MUL_CLASS  6'h00
`define ENC_MUL_NIB    4'h9

// ****************************************************************
// Exec state register fields
// ****************************************************************
`define ST_DONE_BIT   0
`define ST_BUSY_BIT   1
`define ST_WROTE_BIT  2
`define ST_PASS_BIT   3

`define AXI_OKAY   2'h0
`define AXI_SLVERR 2'h2

`endif

/* File: hw/psr_mul_pkg.sv */
package psr_mul_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ISSUE,
		ST_ARRAY,
		ST_ACCUM,
		ST_FINISH
	} exec_state_e;

	typedef enum logic [2:0] {
		K_NONE,
		K_READ,
		K_WRITE_ALL,
		K_WRITE_FLG,
		K_MUL
	} instr_kind_e;

endpackage

/* File: hw/psr_transfer_multiply_exec.sv */
`timescale 1ns/1ps
`include "psr_mul_map.svh"
// Functional notes
// - Skip instruction when condition fails
// - Status transfers decoded from compare space
// - Status read copies current or saved word
// - Flag write touches only bits 31:28
// - Operand bits 31..28 map to N,Z,C,V
// - User mode blocks control bit writes
// - Privileged full write replaces whole word
// - Saved word chosen by current mode
// - Only twelve status bits are defined
// - Status transfer takes one cycle
// - Multiply steps eight multiplier bits per cycle
// - Plain multiply ignores accumulate register
// - Accumulate form adds accumulate register
// - Only low 32 product bits returned
// - Flag update sets N and Z
// - Multiply leaves C unspecified, V unchanged
// - Multiply costs m+1, accumulate m+2 cycles
// - Early termination on sign-extended multiplier
// - Other register aliasing still gives correct results
module psr_transfer_multiply_exec #(
	parameter int ADDR_W = 6
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	psr_mul_pkg::exec_state_e state;
	psr_mul_pkg::instr_kind_e kind;
	logic [ADDR_W-1:0] aw_addr;
	logic              aw_held;
	logic [31:0]       w_data;
	logic [3:0]        w_strb;
	logic              w_held;
	logic              wr_fire;
	logic              wr_known;
	logic [31:0]       instr;
	logic [31:0]       op_first;
	logic [31:0]       op_mult;
	logic [31:0]       op_acc;
	logic [31:0]       cur_status;
	logic [31:0]       saved_bank [`SAVED_BANKS];
	logic [31:0]       saved_sel;
	logic [2:0]        bank;
	logic [31:0]       result;
	logic [31:0]       prod;
	logic [1:0]        step;
	logic [2:0]        m_count;
	logic [2:0]        m_calc;
	logic              ext_ones;
	logic [3:0]        cycle_cnt;
	logic [3:0]        exec_cycles;
	logic              done;
	logic              wrote_dest;
	logic              cond_pass;
	logic              cond_ok;
	logic              start;
	logic [31:0]       imm_val;
	logic [63:0]       imm_rot;
	logic [31:0]       msr_src;
	logic [31:0]       partial;
	logic [31:0]       rd_mux;
	logic              rd_known;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic cond_eval(input logic [3:0] c, input logic [3:0] f);
		logic n, z, cy, v, r;
		n = f[3];
		z = f[2];
		cy = f[1];
		v = f[0];
		case (c[3:1])
			3'h0: r = z;
			3'h1: r = cy;
			3'h2: r = n;
			3'h3: r = v;
			3'h4: r = cy & ~z;
			3'h5: r = (n == v);
			3'h6: r = ~z & (n == v);
			default: r = 1'b1;
		endcase
		if (c == 4'hF) begin
			return 1'b0;
		end
		return (c == 4'hE) ? 1'b1 : (r ^ c[0]);
	endfunction

	function automatic logic [2:0] bank_of(input logic [4:0] md);
		case (md)
			`MODE_FAST: return 3'h0;
			`MODE_IRQ: return 3'h1;
			`MODE_SVC: return 3'h2;
			`MODE_ABT: return 3'h3;
			`MODE_UND: return 3'h4;
			default: return `BANK_NONE;
		endcase
	endfunction

	// ****************************************************************
	// Decode
	// ****************************************************************
	always_comb begin
		kind = psr_mul_pkg::K_NONE;
		if (instr[27:23] == `ENC_PSR_CLASS && !instr[20]) begin
			if (instr[21:16] == `ENC_READ_MID && instr[11:0] == 12'h000) begin
				kind = psr_mul_pkg::K_READ;
			end else if (instr[21:12] == `ENC_WRITE_ALL && instr[11:4] == 8'h00) begin
				kind = psr_mul_pkg::K_WRITE_ALL;
			end
		end
		if (instr[27:26] == 2'b00 && instr[24:23] == 2'b10 && instr[21:12] == `ENC_WRITE_FLG) begin
			kind = psr_mul_pkg::K_WRITE_FLG;
		end
		if (instr[27:22] == `ENC_MUL_CLASS && instr[7:4] == `ENC_MUL_NIB) begin
			kind = psr_mul_pkg::K_MUL;
		end
	end

	assign cond_ok = cond_eval(instr[31:28], cur_status[31:28]);
	assign bank = bank_of(cur_status[4:0]);
	assign saved_sel = (bank == `BANK_NONE) ? 32'h00000000 : saved_bank[bank];
	assign imm_val = {24'h000000, instr[7:0]};
	assign imm_rot = {imm_val, imm_val} >> {instr[11:8], 1'b0};
	assign msr_src = (instr[25] && kind == psr_mul_pkg::K_WRITE_FLG) ? imm_rot[31:0] : op_first;

	// Early termination width
	always_comb begin
		if (&op_mult[31:8] || ~|op_mult[31:8]) begin
			m_calc = 3'h1;
		end else if (&op_mult[31:16] || ~|op_mult[31:16]) begin
			m_calc = 3'h2;
		end else if (&op_mult[31:24] || ~|op_mult[31:24]) begin
			m_calc = 3'h3;
		end else begin
			m_calc = 3'h4;
		end
	end

	// ****************************************************************
	// AXI4-Lite write channel
	// ****************************************************************
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;
	assign start = wr_fire && aw_addr[5:2] == `REG_INSTR >> 2 && state == psr_mul_pkg::ST_IDLE;
	assign wr_known = aw_addr[ADDR_W-1:2] <= (`REG_EXEC_STATE >> 2);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `AXI_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
				aw_held <= 1'b1;
				s_axi_awready <= 1'b0;
			end else if (!aw_held && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				w_held <= 1'b1;
				s_axi_wready <= 1'b0;
			end else if (!w_held && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? `AXI_OKAY : `AXI_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Operand registers, frozen while busy
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			instr <= 32'h00000000;
			op_first <= 32'h00000000;
			op_mult <= 32'h00000000;
			op_acc <= 32'h00000000;
		end else if (wr_fire && state == psr_mul_pkg::ST_IDLE) begin
			case (aw_addr[5:0] & 6'h3C)
				`REG_INSTR: instr <= merge(instr, w_data, w_strb);
				`REG_OP_FIRST: op_first <= merge(op_first, w_data, w_strb);
				`REG_OP_MULT: op_mult <= merge(op_mult, w_data, w_strb);
				`REG_OP_ACC: op_acc <= merge(op_acc, w_data, w_strb);
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// AXI4-Lite read channel
	// ****************************************************************
	always_comb begin
		rd_known = 1'b1;
		case (s_axi_araddr[5:0] & 6'h3C)
			`REG_INSTR: rd_mux = instr;
			`REG_OP_FIRST: rd_mux = op_first;
			`REG_OP_MULT: rd_mux = op_mult;
			`REG_OP_ACC: rd_mux = op_acc;
			`REG_CUR_STATUS: rd_mux = cur_status;
			`REG_SAVED_STATUS: rd_mux = saved_sel;
			`REG_RESULT: rd_mux = result;
			`REG_EXEC_STATE: rd_mux = {12'h000, exec_cycles, 1'b0, m_count, instr[15:12],
				4'h0, cond_pass, wrote_dest, state != psr_mul_pkg::ST_IDLE, done};
			default: begin
				rd_mux = 32'h00000000;
				rd_known = 1'b0;
			end
		endcase
		if (s_axi_araddr[ADDR_W-1:2] > (`REG_EXEC_STATE >> 2)) begin
			rd_mux = 32'h00000000;
			rd_known = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `AXI_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= rd_known ? `AXI_OKAY : `AXI_SLVERR;
		end else begin
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= psr_mul_pkg::ST_IDLE;
			cycle_cnt <= 4'h0;
			cond_pass <= 1'b0;
		end else begin
			case (state)
				psr_mul_pkg::ST_IDLE: begin
					cycle_cnt <= 4'h0;
					if (start) begin
						state <= psr_mul_pkg::ST_ISSUE;
					end
				end
				psr_mul_pkg::ST_ISSUE: begin
					cycle_cnt <= cycle_cnt + 4'h1;
					cond_pass <= cond_ok;
					if (kind == psr_mul_pkg::K_MUL && cond_ok) begin
						state <= psr_mul_pkg::ST_ARRAY;
					end else begin
						state <= psr_mul_pkg::ST_FINISH;
					end
				end
				psr_mul_pkg::ST_ARRAY: begin
					cycle_cnt <= cycle_cnt + 4'h1;
					if ({1'b0, step} == m_count - 3'h1) begin
						state <= instr[21] ? psr_mul_pkg::ST_ACCUM : psr_mul_pkg::ST_FINISH;
					end
				end
				psr_mul_pkg::ST_ACCUM: begin
					cycle_cnt <= cycle_cnt + 4'h1;
					state <= psr_mul_pkg::ST_FINISH;
				end
				psr_mul_pkg::ST_FINISH: state <= psr_mul_pkg::ST_IDLE;
				default: state <= psr_mul_pkg::ST_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Multiplier array
	// ****************************************************************
	assign partial = op_first * {24'h000000, op_mult[{step, 3'b000} +: 8]};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prod <= 32'h00000000;
			step <= 2'h0;
			m_count <= 3'h0;
			ext_ones <= 1'b0;
		end else if (state == psr_mul_pkg::ST_ISSUE) begin
			prod <= 32'h00000000;
			step <= 2'h0;
			m_count <= m_calc;
			ext_ones <= op_mult[31] && m_calc != 3'h4;
		end else if (state == psr_mul_pkg::ST_ARRAY) begin
			step <= step + 2'h1;
			if ({1'b0, step} == m_count - 3'h1 && ext_ones) begin
				prod <= prod + (partial << {step, 3'b000})
					- (op_first << {m_count[1:0], 3'b000});
			end else begin
				prod <= prod + (partial << {step, 3'b000});
			end
		end else if (state == psr_mul_pkg::ST_ACCUM) begin
			prod <= prod + op_acc;
		end
	end

	// ****************************************************************
	// Result and completion
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result <= 32'h00000000;
			done <= 1'b0;
			wrote_dest <= 1'b0;
			exec_cycles <= 4'h0;
		end else if (start) begin
			done <= 1'b0;
			wrote_dest <= 1'b0;
		end else if (state == psr_mul_pkg::ST_FINISH) begin
			done <= 1'b1;
			exec_cycles <= cycle_cnt;
			if (cond_pass && kind == psr_mul_pkg::K_READ) begin
				result <= instr[22] ? saved_sel : cur_status;
				wrote_dest <= 1'b1;
			end else if (cond_pass && kind == psr_mul_pkg::K_MUL) begin
				result <= prod;
				wrote_dest <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Status words
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cur_status <= `PSR_RESET;
			for (int i = 0; i < `SAVED_BANKS; i++) begin
				saved_bank[i] <= 32'h00000000;
			end
		end else if (wr_fire && state == psr_mul_pkg::ST_IDLE) begin
			if ((aw_addr[5:0] & 6'h3C) == `REG_CUR_STATUS) begin
				cur_status <= merge(cur_status, w_data, w_strb) & `PSR_DEFINED_MASK;
			end else if ((aw_addr[5:0] & 6'h3C) == `REG_SAVED_STATUS && bank != `BANK_NONE) begin
				saved_bank[bank] <= merge(saved_sel, w_data, w_strb) & `PSR_DEFINED_MASK;
			end
		end else if (state == psr_mul_pkg::ST_FINISH && cond_pass) begin
			if (kind == psr_mul_pkg::K_WRITE_FLG || kind == psr_mul_pkg::K_WRITE_ALL) begin
				if (instr[22]) begin
					if (bank != `BANK_NONE) begin
						saved_bank[bank] <= (kind == psr_mul_pkg::K_WRITE_ALL) ?
							(msr_src & `PSR_DEFINED_MASK) :
							{msr_src[31:28], saved_sel[27:0]};
					end
				end else if (kind == psr_mul_pkg::K_WRITE_FLG || cur_status[4:0] == `MODE_USR) begin
					cur_status[31:28] <= msr_src[31:28];
				end else begin
					cur_status <= msr_src & `PSR_DEFINED_MASK;
				end
			end else if (kind == psr_mul_pkg::K_MUL && instr[20]) begin
				cur_status[`PSR_N] <= prod[31];
				cur_status[`PSR_Z] <= (prod == 32'h00000000);
			end
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	AST_COND_SKIP: assert property (state == psr_mul_pkg::ST_FINISH && !cond_pass
		|=> $stable(cur_status) && !wrote_dest) else $error("failed condition changed state");
	AST_PSR_SPACE: assert property ((kind == psr_mul_pkg::K_READ ||
		kind == psr_mul_pkg::K_WRITE_FLG) |-> instr[24:23] == 2'b10 && !instr[20])
		else $error("status transfer outside compare space");
	AST_READ_COPY: assert property (state == psr_mul_pkg::ST_FINISH && cond_pass &&
		kind == psr_mul_pkg::K_READ |=> result == (instr[22] ? $past(saved_sel) : $past(cur_status)))
		else $error("status read wrong value");
	AST_FLAG_WRITE: assert property (state == psr_mul_pkg::ST_FINISH && cond_pass &&
		kind == psr_mul_pkg::K_WRITE_FLG && !instr[22] |=> cur_status[27:0] == $past(cur_status[27:0])
		&& cur_status[31:28] == $past(msr_src[31:28])) else $error("flag write wrong");
	AST_USER_GUARD: assert property (state == psr_mul_pkg::ST_FINISH && cond_pass &&
		kind == psr_mul_pkg::K_WRITE_ALL && !instr[22] && cur_status[4:0] == `MODE_USR
		|=> cur_status[27:0] == $past(cur_status[27:0])) else $error("user control bits changed");
	AST_PRIV_FULL: assert property (state == psr_mul_pkg::ST_FINISH && cond_pass &&
		kind == psr_mul_pkg::K_WRITE_ALL && !instr[22] && cur_status[4:0] != `MODE_USR
		|=> cur_status == ($past(msr_src) & `PSR_DEFINED_MASK)) else $error("full write wrong");
	AST_RESERVED: assert property ((cur_status & ~`PSR_DEFINED_MASK) == 32'h00000000)
		else $error("reserved status bits set");
	AST_XFER_TIME: assert property (state == psr_mul_pkg::ST_ISSUE &&
		kind != psr_mul_pkg::K_MUL |=> state == psr_mul_pkg::ST_FINISH ##1
		state == psr_mul_pkg::ST_IDLE) else $error("status transfer timing");
	AST_MUL_TIME: assert property (state == psr_mul_pkg::ST_FINISH && cond_pass &&
		kind == psr_mul_pkg::K_MUL |-> cycle_cnt == {1'b0, m_count} +
		{3'h0, instr[21]} + 4'h1) else $error("multiply cycle count");
	AST_EARLY: assert property (state == psr_mul_pkg::ST_ISSUE |=> m_count ==
		(($signed(op_mult) >= -256 && $signed(op_mult) < 0) || op_mult < 32'h100 ? 3'h1 :
		(op_mult[31:16] == 16'hFFFF || op_mult[31:16] == 16'h0000) ? 3'h2 :
		(op_mult[31:24] == 8'hFF || op_mult[31:24] == 8'h00) ? 3'h3 : 3'h4))
		else $error("early termination count");
	AST_PRODUCT: assert property (
		state == psr_mul_pkg::ST_FINISH && cond_pass &&
		kind == psr_mul_pkg::K_MUL |=> result == 32'(op_first * op_mult +
		(instr[21] ? op_acc : 32'h00000000))) else $error("product wrong");
	AST_MUL_FLAGS: assert property (state == psr_mul_pkg::ST_FINISH && cond_pass &&
		kind == psr_mul_pkg::K_MUL && instr[20] |=> cur_status[`PSR_N] == result[31] &&
		cur_status[`PSR_Z] == (result == 32'h00000000) &&
		cur_status[`PSR_V] == $past(cur_status[`PSR_V]))
		else $error("multiply flags wrong");

	COV_MLA: cover property (state == psr_mul_pkg::ST_ACCUM);
	COV_ONES: cover property (state == psr_mul_pkg::ST_ISSUE && kind == psr_mul_pkg::K_MUL
		&& m_calc == 3'h1 && op_mult[31]);
	COV_FLG: cover property (state == psr_mul_pkg::ST_FINISH && kind == psr_mul_pkg::K_WRITE_FLG);
	COV_SKIP: cover property (state == psr_mul_pkg::ST_FINISH && !cond_pass);

endmodule

/* File: tb/core_side_model.sv */
`timescale 1ns/1ps
module core_side_model (
	input  wire logic        aclk,
	output logic [5:0]       s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic [5:0]       s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	// ****************************************
	// Idle bus from time zero
	// ****************************************
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end
	// ****************************************
	// Bus transfers
	// ****************************************
	task automatic write(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
		bit aw_done = 1'b0;
		bit w_done = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		forever begin
			@(posedge aclk);
			if (!aw_done && s_axi_awready) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic read(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
		bit ar_done = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		forever begin
			@(posedge aclk);
			if (!ar_done && s_axi_arready) begin
				ar_done = 1'b1;
				s_axi_arvalid <= 1'b0;
			end
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask
endmodule

/* File: tb/test_psr_transfer_multiply_exec.sv */
`timescale 1ns/1ps
`include "psr_mul_map.svh"
`define CHK(nm, e, g) begin \
	n_checks++; \
	if ((g) !== (e)) begin \
		err_count++; \
		$display("Error %s expected %h seen %h", nm, e, g); \
	end \
end
module test_psr_transfer_multiply_exec;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [5:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int          err_count = 0;
	int          n_checks = 0;
	int          cyc = 0;
	logic [31:0] cur;
	logic [31:0] sav [0:31];
	logic [31:0] d;
	logic [31:0] st;
	logic [31:0] r;
	logic [1:0]  rsp;

	psr_transfer_multiply_exec i_dut (.*);
	core_side_model i_core (.*);

	// ****************************************
	// Clock, timeout, verdict
	// ****************************************
	always #2.5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_count++;
			complete_run();
		end
	end
	task automatic complete_run();
		if (err_count == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// ****************************************
	// Reference model and operations
	// ****************************************
	function automatic logic [31:0] saved_now();
		return (cur[4:0] == `MODE_USR || cur[4:0] == 5'h1F) ? 32'h0 : sav[cur[4:0]];
	endfunction
	task automatic run(input logic [31:0] ins, input logic [3:0] n, input logic ok,
		input logic wr);
		int k = 0;
		i_core.write(`REG_INSTR, ins, rsp);
		do begin
			i_core.read(`REG_EXEC_STATE, st, rsp);
			k++;
		end while (st[`ST_DONE_BIT] !== 1'b1 && k < 40);
		`CHK("cond pass", ok, st[`ST_PASS_BIT])
		`CHK("dest written", wr, st[`ST_WROTE_BIT])
		`CHK("cycles", n, st[19:16])
	endtask
	task automatic read_chk(input logic ps);
		run(32'hE10F0000 | {9'h0, ps, 22'h0}, 4'h1, 1'b1, 1'b1);
		i_core.read(`REG_RESULT, d, rsp);
		`CHK("status read", ps ? saved_now() : cur, d)
	endtask
	task automatic write_chk(input logic ps, input logic flg, input logic imm, input logic [31:0] v);
		logic [31:0] t;
		i_core.write(`REG_OP_FIRST, v, rsp);
		run(imm ? 32'hE328F400 | {9'h0, ps, 14'h0, v[31:24]}
			: 32'hE128F000 | {9'h0, ps, 5'h0, !flg, 16'h0}, 4'h1, 1'b1, 1'b0);
		t = ps ? saved_now() : cur;
		if (flg || (!ps && cur[4:0] == `MODE_USR)) t[31:28] = v[31:28];
		else t = v & `PSR_DEFINED_MASK;
		if (ps) sav[cur[4:0]] = t;
		else cur = t;
		read_chk(ps);
	endtask
	task automatic mode_set(input logic [4:0] md);
		write_chk(1'b0, 1'b0, 1'b0, {cur[31:5], md});
	endtask
	task automatic mul(input logic [3:0] cnd, input logic acc, input logic s,
		input logic [31:0] a, input logic [31:0] b);
		logic [31:0] c;
		logic [31:0] p;
		logic [31:0] t;
		logic        ok;
		int          m = 4;
		c = $urandom;
		i_core.write(`REG_OP_FIRST, a, rsp);
		i_core.write(`REG_OP_MULT, b, rsp);
		i_core.write(`REG_OP_ACC, c, rsp);
		for (int k = 3; k >= 1; k--) begin
			t = $signed(b) >>> (8 * k);
			if (t == 32'h0 || t == 32'hFFFFFFFF) m = k;
		end
		ok = cnd == 4'hE || (cnd == 4'h0 && cur[30]) || (cnd == 4'h1 && !cur[30]);
		p = a * b + (acc ? c : 32'h0);
		run({cnd, 6'h0, acc, s, 12'h555, 4'h9, 4'h4}, ok ? 4'(m + acc + 1) : 4'h1, ok, ok);
		i_core.read(`REG_RESULT, d, rsp);
		if (ok) begin
			`CHK("array cycles", 3'(m), st[14:12])
			`CHK("product", p, d)
			if (s) cur[31:30] = {p[31], p == 32'h0};
		end
		i_core.read(`REG_CUR_STATUS, d, rsp);
		cur[29] = d[29];
		`CHK("flags", cur, d)
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		void'($urandom(11));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		cur = `PSR_RESET;
		foreach (sav[k]) sav[k] = 32'h0;
		i_core.read(`REG_CUR_STATUS, d, rsp);
		`CHK("reset status", `PSR_RESET, d)
		i_core.read(6'h20, d, rsp);
		`CHK("unmapped read", {`AXI_SLVERR, 32'h0}, {rsp, d})
		i_core.write(6'h24, 32'h1, rsp);
		`CHK("unmapped write", `AXI_SLVERR, rsp)
		read_chk(1'b0);
		read_chk(1'b1);
		for (int i = 0; i < 6; i++) begin
			r = $urandom;
			write_chk(i[0], 1'b1, i[1], {i == 0 ? 4'hA : r[31:28], i[1] ? 28'h0 : r[27:0]});
		end
		mode_set(`MODE_FAST);
		write_chk(1'b1, 1'b0, 1'b0, 32'h900000D2);
		write_chk(1'b1, 1'b1, 1'b0, $urandom);
		mode_set(`MODE_IRQ);
		read_chk(1'b1);
		write_chk(1'b0, 1'b0, 1'b0, 32'h50000011);
		read_chk(1'b1);
		run(32'hE11F0000, 4'h1, 1'b1, 1'b0);
		mul(4'hE, 1'b0, 1'b1, 32'hFFFFFFF6, 32'h00000014);
		mul(4'hE, 1'b0, 1'b1, 32'h0, $urandom);
		for (int i = 0; i < 8; i++) begin
			r = $urandom;
			d = (32'h1 << ((i % 4) * 8 + 8)) - 32'h1;
			d = (i % 4 == 3) ? {2'b01, r[29:0]} : (r[31] ? r | ~d : r & d);
			mul(4'hE, i[2], i[0] ^ i[2], $urandom, d);
		end
		for (int j = 0; j < 4; j++) begin
			write_chk(1'b0, 1'b1, 1'b1, {1'b0, j[1], 30'h0});
			mul({3'h0, j[0]}, j[1], 1'b0, $urandom, $urandom);
		end
		mode_set(`MODE_USR);
		write_chk(1'b0, 1'b0, 1'b0, 32'hA00000D3);
		write_chk(1'b0, 1'b1, 1'b1, 32'h50000000);
		complete_run();
	end
endmodule
